// ### rtl/cpu_regs_regs.svh
// Register offsets, flag bit positions and field widths for the core register set.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef CPU_REGS_REGS_SVH
`define CPU_REGS_REGS_SVH

// Register byte offsets on the APB side.
`define OFF_DATA0 12'h000
`define OFF_DATA1 12'h004
`define OFF_DATA2 12'h008
`define OFF_DATA3 12'h00C
`define OFF_ADDR0 12'h010
`define OFF_ADDR1 12'h014
`define OFF_FBASE 12'h018
`define OFF_VTBASE 12'h01C
`define OFF_NIP 12'h020
`define OFF_USP 12'h024
`define OFF_ISP 12'h028
`define OFF_SBASE 12'h02C
`define OFF_FLAGS 12'h030
`define OFF_ACT_SP 12'h034
`define OFF_DPAIR_LO 12'h038
`define OFF_DPAIR_HI 12'h03C
`define OFF_APAIR 12'h040
`define OFF_D0_LOWER 12'h044
`define OFF_D0_UPPER 12'h048
`define OFF_D1_LOWER 12'h04C
`define OFF_D1_UPPER 12'h050

// Flag register bit positions.
`define FLG_C 0
`define FLG_D 1
`define FLG_Z 2
`define FLG_S 3
`define FLG_B 4
`define FLG_O 5
`define FLG_I 6
`define FLG_U 7
`define FLG_IPL_LO 8
`define FLG_IPL_HI 10

// Widths and limits.
`define FLG_W 11
`define WIDE_W 20
`define SW_INT_U_MAX 6'h1F

// Reset values.
`define RST_FLAGS 11'h000
`define RST_WORD16 16'h0000
`define RST_WORD20 20'h00000

`endif

// ### rtl/cpu_regs_pkg.sv
// Types for the core register set: the whole state of the block as one packed struct.
// Assumes cpu_regs_regs.svh is on the include path.
`include "cpu_regs_regs.svh"

package cpu_regs_pkg;

    // Complete registered state of the register set and its APB answer.
    typedef struct packed {
        logic [1:0][3:0][15:0] data;
        logic [1:0][1:0][15:0] addr;
        logic [1:0][15:0] fbase;
        logic [`WIDE_W-1:0] vtbase;
        logic [`WIDE_W-1:0] nip;
        logic [15:0] user_stack_ptr;
        logic [15:0] interrupt_stack_ptr;
        logic [15:0] sbase;
        logic [`FLG_W-1:0] flags;
        logic [15:0] active_sp;
        logic irq_accept;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } regset_s;

endpackage : cpu_regs_pkg

// ### rtl/cpu_register_set_and_flags.sv
// Architectural register set and flag register of a small 16-bit core, with APB access.
// Assumes the execution unit and interrupt logic run on pclk and drive the core-side
// inputs synchronously, so none of them is synchronised here.
//
// Design decisions made here: register access over APB and the placing of the registers.
`include "cpu_regs_regs.svh"

////////////////////////////////////////////////////////////////////////////////////////////

module cpu_register_set_and_flags import cpu_regs_pkg::*; (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Execution unit result flags.
    input wire logic alu_update,
    input wire logic [15:0] alu_result,
    input wire logic alu_carry,
    input wire logic alu_overflow,
    // Instruction pointer load.
    input wire logic nip_load,
    input wire logic [`WIDE_W-1:0] nip_value,
    // Interrupt request and software interrupt.
    input wire logic irq_request,
    input wire logic [2:0] irq_priority,
    input wire logic sw_int,
    input wire logic [5:0] sw_int_num,
    // Core-side views.
    output logic irq_accept,
    output logic [`FLG_W-1:0] processor_state_flags,
    output logic [15:0] active_stack_ptr
);

    ////////////////////////////////////////////////////////////////////////////////////////

    regset_s st_r;
    regset_s st_nxt;
    logic bk;
    logic [2:0] ipl_now;
    logic [15:0] wd16;
    logic take_irq;

    // Convenience views used by the decode and the checks.
    assign bk = st_r.flags[`FLG_B];
    assign ipl_now = st_r.flags[`FLG_IPL_HI:`FLG_IPL_LO];
    assign wd16 = pwdata[15:0];

    // Maskable acceptance needs enable set and a strictly higher request priority.
    assign take_irq = irq_request && st_r.flags[`FLG_I] && (irq_priority > ipl_now);

    ////////////////////////////////////////////////////////////////////////////////////////

    // Next-state logic. The read answer is prepared on the first access edge and the
    // write commits on the edge where the master sees pready, so a write lands once per
    // pready pulse; a master that holds the access past pready gets a second pulse and write.
    always_comb begin
        logic [31:0] rd;
        logic miss;
        logic commit;
        rd = 32'h0000_0000;
        miss = 1'b0;
        commit = 1'b0;
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.irq_accept = 1'b0;

        // Read decode against the active bank.
        if (paddr[11:4] == 8'h00 && paddr[1:0] == 2'b00) begin
            rd = {16'h0000, st_r.data[bk][paddr[3:2]]};
        end else if (paddr == `OFF_ADDR0) begin
            rd = {16'h0000, st_r.addr[bk][0]};
        end else if (paddr == `OFF_ADDR1) begin
            rd = {16'h0000, st_r.addr[bk][1]};
        end else if (paddr == `OFF_FBASE) begin
            rd = {16'h0000, st_r.fbase[bk]};
        end else if (paddr == `OFF_VTBASE) begin
            rd = {12'h000, st_r.vtbase};
        end else if (paddr == `OFF_NIP) begin
            rd = {12'h000, st_r.nip};
        end else if (paddr == `OFF_USP) begin
            rd = {16'h0000, st_r.user_stack_ptr};
        end else if (paddr == `OFF_ISP) begin
            rd = {16'h0000, st_r.interrupt_stack_ptr};
        end else if (paddr == `OFF_SBASE) begin
            rd = {16'h0000, st_r.sbase};
        end else if (paddr == `OFF_FLAGS) begin
            rd = {21'h000000, st_r.flags};
        end else if (paddr == `OFF_ACT_SP) begin
            rd = {16'h0000, st_r.active_sp};
        end else if (paddr == `OFF_DPAIR_LO) begin
            rd = {st_r.data[bk][2], st_r.data[bk][0]};
        end else if (paddr == `OFF_DPAIR_HI) begin
            rd = {st_r.data[bk][3], st_r.data[bk][1]};
        end else if (paddr == `OFF_APAIR) begin
            rd = {st_r.addr[bk][1], st_r.addr[bk][0]};
        end else if (paddr == `OFF_D0_LOWER) begin
            rd = {24'h000000, st_r.data[bk][0][7:0]};
        end else if (paddr == `OFF_D0_UPPER) begin
            rd = {24'h000000, st_r.data[bk][0][15:8]};
        end else if (paddr == `OFF_D1_LOWER) begin
            rd = {24'h000000, st_r.data[bk][1][7:0]};
        end else if (paddr == `OFF_D1_UPPER) begin
            rd = {24'h000000, st_r.data[bk][1][15:8]};
        end else begin
            miss = 1'b1;
        end

        // First access edge: raise pready with the answer already in place.
        if (psel && penable && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = miss;
            st_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
        end

        // Completing edge: commit the write to the active bank.
        commit = psel && penable && st_r.pready && pwrite && !st_r.pslverr;
        if (commit) begin
            if (paddr[11:4] == 8'h00) begin
                st_nxt.data[bk][paddr[3:2]] = pwdata[15:0];
            end else if (paddr == `OFF_ADDR0) begin
                st_nxt.addr[bk][0] = pwdata[15:0];
            end else if (paddr == `OFF_ADDR1) begin
                st_nxt.addr[bk][1] = pwdata[15:0];
            end else if (paddr == `OFF_FBASE) begin
                st_nxt.fbase[bk] = pwdata[15:0];
            end else if (paddr == `OFF_VTBASE) begin
                st_nxt.vtbase = pwdata[`WIDE_W-1:0];
            end else if (paddr == `OFF_NIP) begin
                st_nxt.nip = pwdata[`WIDE_W-1:0];
            end else if (paddr == `OFF_USP) begin
                st_nxt.user_stack_ptr = pwdata[15:0];
            end else if (paddr == `OFF_ISP) begin
                st_nxt.interrupt_stack_ptr = pwdata[15:0];
            end else if (paddr == `OFF_SBASE) begin
                st_nxt.sbase = pwdata[15:0];
            end else if (paddr == `OFF_FLAGS) begin
                // Upper reserved bits are dropped; the debug bit is stored as written.
                st_nxt.flags = pwdata[`FLG_W-1:0];
            end else if (paddr == `OFF_ACT_SP) begin
                if (st_r.flags[`FLG_U]) begin
                    st_nxt.user_stack_ptr = pwdata[15:0];
                end else begin
                    st_nxt.interrupt_stack_ptr = pwdata[15:0];
                end
            end else if (paddr == `OFF_DPAIR_LO) begin
                st_nxt.data[bk][0] = pwdata[15:0];
                st_nxt.data[bk][2] = pwdata[31:16];
            end else if (paddr == `OFF_DPAIR_HI) begin
                st_nxt.data[bk][1] = pwdata[15:0];
                st_nxt.data[bk][3] = pwdata[31:16];
            end else if (paddr == `OFF_APAIR) begin
                st_nxt.addr[bk][0] = pwdata[15:0];
                st_nxt.addr[bk][1] = pwdata[31:16];
            end else if (paddr == `OFF_D0_LOWER) begin
                st_nxt.data[bk][0][7:0] = pwdata[7:0];
            end else if (paddr == `OFF_D0_UPPER) begin
                st_nxt.data[bk][0][15:8] = pwdata[7:0];
            end else if (paddr == `OFF_D1_LOWER) begin
                st_nxt.data[bk][1][7:0] = pwdata[7:0];
            end else if (paddr == `OFF_D1_UPPER) begin
                st_nxt.data[bk][1][15:8] = pwdata[7:0];
            end
        end

        // Hardware events come after the bus write so an event in the same cycle as a
        // software write wins; no flag update is lost to a concurrent clear.
        if (alu_update) begin
            st_nxt.flags[`FLG_C] = alu_carry;
            st_nxt.flags[`FLG_Z] = (alu_result == 16'h0000);
            st_nxt.flags[`FLG_S] = alu_result[15];
            st_nxt.flags[`FLG_O] = alu_overflow;
        end
        if (nip_load) begin
            st_nxt.nip = nip_value;
        end
        if (take_irq) begin
            st_nxt.irq_accept = 1'b1;
            st_nxt.flags[`FLG_I] = 1'b0;
            st_nxt.flags[`FLG_U] = 1'b0;
        end
        if (sw_int && sw_int_num <= `SW_INT_U_MAX) begin
            st_nxt.flags[`FLG_U] = 1'b0;
        end

        // The visible stack pointer tracks the selected one including this cycle's writes.
        st_nxt.active_sp = st_nxt.flags[`FLG_U] ? st_nxt.user_stack_ptr : st_nxt.interrupt_stack_ptr;
    end

    ////////////////////////////////////////////////////////////////////////////////////////

    // State register; everything resets to zero, so bank 0 and the interrupt stack
    // pointer are selected and interrupts are masked after reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign irq_accept = st_r.irq_accept;
    assign processor_state_flags = st_r.flags;
    assign active_stack_ptr = st_r.active_sp;

    ////////////////////////////////////////////////////////////////////////////////////////

    // Checks on the block's own behaviour.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence access_start_s;
        psel && penable && !pready;
    endsequence

    sequence commit_d0_s;
        psel && penable && pready && pwrite && !pslverr && paddr == `OFF_DATA0;
    endsequence

    sequence commit_d0_lower_s;
        psel && penable && pready && pwrite && !pslverr && paddr == `OFF_D0_LOWER;
    endsequence

    apb_answer_a: assert property (access_start_s |=> pready ##1 !pready)
        else $error("pready did not pulse one cycle after access start");

    carry_capture_a: assert property (alu_update |=> processor_state_flags[`FLG_C] == $past(alu_carry))
        else $error("carry flag did not capture the execution unit carry");

    zero_flag_a: assert property (alu_update |=> processor_state_flags[`FLG_Z] == ($past(alu_result) == 16'h0000))
        else $error("zero flag does not match the result");

    sign_flag_a: assert property (alu_update |=> processor_state_flags[`FLG_S] == $past(alu_result[15]))
        else $error("sign flag does not match the result");

    overflow_flag_a: assert property (alu_update |=> processor_state_flags[`FLG_O] == $past(alu_overflow))
        else $error("overflow flag does not match the execution unit");

    irq_clears_enable_a: assert property (irq_accept |-> !processor_state_flags[`FLG_I] && !processor_state_flags[`FLG_U])
        else $error("acknowledge left interrupt enable or stack select set");

    irq_priority_a: assert property (irq_accept |-> $past(irq_priority) > $past(ipl_now))
        else $error("interrupt accepted without strictly higher priority");

    sw_int_stack_a: assert property (sw_int && sw_int_num <= `SW_INT_U_MAX |=> !processor_state_flags[`FLG_U])
        else $error("software interrupt did not clear stack select");

    active_sp_a: assert property (active_stack_ptr == (st_r.flags[`FLG_U] ? st_r.user_stack_ptr : st_r.interrupt_stack_ptr))
        else $error("active stack pointer does not follow stack select");

    bank_route_a: assert property (commit_d0_s |=> st_r.data[$past(bk)][0] == $past(wd16))
        else $error("data write did not land in the selected bank");

    byte_keep_a: assert property (commit_d0_lower_s |=> st_r.data[$past(bk)][0][15:8] == $past(st_r.data[bk][0][15:8]))
        else $error("lower byte write disturbed the upper byte");

    // Completing edge of a write to one offset, and the first access edge of a read.
    sequence commit_at_s(logic [11:0] off);
        psel && penable && pready && pwrite && !pslverr && paddr == off;
    endsequence

    sequence read_at_s(logic [11:0] off);
        psel && penable && !pready && !pwrite && paddr == off;
    endsequence

    // Bus answers: one pulse, only inside an access, error only off the map.
    pready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready raised outside an access");

    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready stood for more than one cycle");

    write_reads_zero_a: assert property (psel && penable && !pready && pwrite |=> prdata == 32'h0)
        else $error("write answer carried nonzero read data");

    unmapped_error_a: assert property (access_start_s ##0 paddr > `OFF_D1_UPPER |=> pslverr)
        else $error("unmapped access answered without error");

    mapped_ok_a: assert property (access_start_s ##0 paddr <= `OFF_D1_UPPER && paddr[1:0] == 2'b00
        |=> !pslverr)
        else $error("mapped access answered with error");

    // Read data against the stored registers.
    flags_reserved_a: assert property (read_at_s(`OFF_FLAGS) |=> prdata[31:11] == 21'h000000)
        else $error("reserved flag bits read nonzero");

    vtbase_read_a: assert property (read_at_s(`OFF_VTBASE) |=> prdata == {12'h000, $past(st_r.vtbase)})
        else $error("vector table base read wrong");

    data0_read_a: assert property (read_at_s(`OFF_DATA0)
        |=> prdata == {16'h0000, $past(st_r.data[bk][0])})
        else $error("first data register read wrong");

    d1_upper_read_a: assert property (read_at_s(`OFF_D1_UPPER)
        |=> prdata == {24'h000000, $past(st_r.data[bk][1][15:8])})
        else $error("second data register upper byte read wrong");

    apair_read_a: assert property (read_at_s(`OFF_APAIR)
        |=> prdata == {$past(st_r.addr[bk][1]), $past(st_r.addr[bk][0])})
        else $error("address pair read wrong");

    // Writes land where they should and nowhere else.
    vtbase_write_a: assert property (commit_at_s(`OFF_VTBASE)
        |=> st_r.vtbase == $past(pwdata[`WIDE_W-1:0]))
        else $error("vector table base write lost");

    pair_upper_a: assert property (commit_at_s(`OFF_DPAIR_LO)
        |=> st_r.data[$past(bk)][2] == $past(pwdata[31:16]))
        else $error("data pair upper half not written");

    pair_lower_a: assert property (commit_at_s(`OFF_DPAIR_LO) |=> st_r.data[$past(bk)][0] == $past(wd16))
        else $error("data pair lower half not written");

    addr_pair_a: assert property (commit_at_s(`OFF_APAIR)
        |=> st_r.addr[$past(bk)][1] == $past(pwdata[31:16]))
        else $error("address pair upper half not written");

    upper_keep_a: assert property (commit_at_s(`OFF_D0_UPPER)
        |=> st_r.data[$past(bk)][0][7:0] == $past(st_r.data[bk][0][7:0]))
        else $error("upper byte write disturbed the lower byte");

    other_bank_a: assert property (commit_d0_s ##0 bk |=> st_r.data[0][0] == $past(st_r.data[0][0]))
        else $error("bank one write disturbed bank zero");

    usp_write_a: assert property (commit_at_s(`OFF_USP) |=> st_r.user_stack_ptr == $past(wd16))
        else $error("user stack pointer write lost");

    flags_write_a: assert property (commit_at_s(`OFF_FLAGS) ##0 !alu_update && !take_irq && !sw_int
        |=> processor_state_flags == $past(pwdata[`FLG_W-1:0]))
        else $error("flag register write lost");

    // Core-side events.
    nip_load_a: assert property (nip_load |=> st_r.nip == $past(nip_value))
        else $error("instruction pointer load lost");

    irq_masked_a: assert property (irq_request && !st_r.flags[`FLG_I] |=> !irq_accept)
        else $error("masked request was accepted");

    irq_low_prio_a: assert property (irq_request && irq_priority <= ipl_now |=> !irq_accept)
        else $error("request at or below the level was accepted");

    irq_take_a: assert property (take_irq |=> irq_accept)
        else $error("eligible request was not accepted");

    isp_after_irq_a: assert property (irq_accept |-> active_stack_ptr == st_r.interrupt_stack_ptr)
        else $error("acknowledge did not select the interrupt stack pointer");

endmodule : cpu_register_set_and_flags

// ### verif/cpu_register_set_and_flags_tb.sv
// Self-checking bench for the core register set: APB register traffic plus core-side events.
// Assumes the rtl/ package and design are compiled first and nothing else drives the block.
`include "cpu_regs_regs.svh"

module cpu_register_set_and_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Stimulus, observed outputs and bookkeeping.
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq_accept;
    logic alu_update = 1'b0, alu_carry = 1'b0, alu_overflow = 1'b0;
    logic [15:0] alu_result = 16'h0000;
    logic nip_load = 1'b0;
    logic [`WIDE_W-1:0] nip_value = 20'h00000;
    logic irq_request = 1'b0, sw_int = 1'b0;
    logic [2:0] irq_priority = 3'h0;
    logic [5:0] sw_int_num = 6'h00;
    logic [`FLG_W-1:0] processor_state_flags;
    logic [15:0] active_stack_ptr;
    logic [31:0] q, d;
    logic [31:0] exp0 [12];
    logic [15:0] r;
    logic [10:0] f;
    logic [2:0] p;
    logic [5:0] n;
    logic [19:0] v;
    logic e, a1, a2;
    int plo [3] = '{0, 1, 4};
    int phi [3] = '{2, 3, 5};
    logic [5:0] sw_tab [4] = '{6'h00, 6'h1F, 6'h20, 6'h3F};
    int cmp_count = 0;
    int miscompares = 0;

    // Design under test, every port driven or observed by the bench.
    cpu_register_set_and_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .alu_update(alu_update), .alu_result(alu_result),
        .alu_carry(alu_carry), .alu_overflow(alu_overflow), .nip_load(nip_load),
        .nip_value(nip_value), .irq_request(irq_request), .irq_priority(irq_priority),
        .sw_int(sw_int), .sw_int_num(sw_int_num), .irq_accept(irq_accept),
        .processor_state_flags(processor_state_flags), .active_stack_ptr(active_stack_ptr));

    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Expected-value functions; the two 20-bit registers sit at word indices 7 and 8.
    function automatic logic [31:0] mask_of(input int i);
        return (i == 7 || i == 8) ? 32'h000FFFFF : 32'h0000FFFF;
    endfunction : mask_of

    function automatic logic [10:0] alu_flags(input logic [15:0] res, input logic c,
                                              input logic o);
        return {5'h00, o, 1'b0, res[15], res == 16'h0000, 1'b0, c};
    endfunction : alu_flags

    function automatic logic take(input logic [10:0] fl, input logic [2:0] pr);
        return fl[6] && (pr > fl[10:8]);
    endfunction : take

    // One comparison; a mismatch is reported at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check

    // One APB transfer; the request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rq, output logic err);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) miscompares++;
        rq = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, output logic [31:0] rq);
        logic err;
        apb(1'b0, a, 32'h0, rq, err);
        check({31'h0, err}, 32'h0);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] rq;
        logic err;
        apb(1'b1, a, wd, rq, err);
        check({31'h0, err}, 32'h0);
    endtask : wr

    // Core-side pulses; alu and pulse_core return at a falling edge so outputs have settled.
    task automatic alu(input logic [15:0] res, input logic c, input logic o);
        @(posedge pclk);
        alu_update <= 1'b1;
        alu_result <= res;
        alu_carry <= c;
        alu_overflow <= o;
        @(posedge pclk);
        alu_update <= 1'b0;
        @(negedge pclk);
    endtask : alu

    // The request stays up one cycle past the answer, so a second accept would show.
    task automatic irq(input logic [2:0] pr, output logic acc, output logic again);
        @(posedge pclk);
        irq_request <= 1'b1;
        irq_priority <= pr;
        @(negedge pclk);
        @(negedge pclk);
        acc = irq_accept;
        @(negedge pclk);
        again = irq_accept;
        @(posedge pclk);
        irq_request <= 1'b0;
    endtask : irq

    task automatic pulse_core(input logic sel_sw, input logic [5:0] num, input logic [19:0] nv);
        @(posedge pclk);
        sw_int <= sel_sw;
        sw_int_num <= num;
        nip_load <= ~sel_sw;
        nip_value <= nv;
        @(posedge pclk);
        sw_int <= 1'b0;
        nip_load <= 1'b0;
        @(negedge pclk);
    endtask : pulse_core

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs well under a tenth of this span.
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end

    // Main sequence: reset, banks and widths, pairs, halves, flags, interrupts.
    initial begin
        void'($urandom(32'h8D2374D8));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            rd(12'(i * 4), q);
            check(q, 32'h0);
        end
        for (int i = 0; i < 12; i++) begin
            d = $urandom();
            wr(12'(i * 4), d);
            exp0[i] = d & mask_of(i);
        end
        wr(`OFF_FLAGS, 32'h010);
        for (int i = 0; i < 12; i++) begin
            rd(12'(i * 4), q);
            if (i > 6) check(q, exp0[i]);
            d = $urandom() & mask_of(i);
            if (i < 7) wr(12'(i * 4), d);
            if (i < 7) rd(12'(i * 4), q);
            if (i < 7) check(q, d);
        end
        wr(`OFF_FLAGS, 32'h000);
        for (int i = 0; i < 12; i++) begin
            rd(12'(i * 4), q);
            check(q, exp0[i]);
        end
        // Pair writes must land in both halves at once.
        for (int k = 0; k < 3; k++) begin
            d = $urandom();
            wr(`OFF_DPAIR_LO + 12'(k * 4), d);
            exp0[plo[k]] = {16'h0, d[15:0]};
            exp0[phi[k]] = {16'h0, d[31:16]};
            rd(12'(plo[k] * 4), q);
            check(q, exp0[plo[k]]);
            rd(12'(phi[k] * 4), q);
            check(q, exp0[phi[k]]);
        end
        // Byte-half writes must leave the other half alone.
        for (int k = 0; k < 4; k++) begin
            d = $urandom();
            wr(`OFF_D0_LOWER + 12'(k * 4), d);
            if (k[0]) exp0[k / 2][15:8] = d[7:0];
            else exp0[k / 2][7:0] = d[7:0];
            rd(12'(k / 2 * 4), q);
            check(q, exp0[k / 2]);
        end
        for (int u = 0; u < 2; u++) begin
            wr(`OFF_FLAGS, 32'(u) << 7);
            rd(`OFF_ACT_SP, q);
            check(q, exp0[u ? 9 : 10]);
            check({16'h0, active_stack_ptr}, exp0[u ? 9 : 10]);
        end
        // Software keeps the debug flag and the reserved bits at zero.
        d = $urandom() & 32'h0000_07FD;
        wr(`OFF_FLAGS, d);
        rd(`OFF_FLAGS, q);
        check(q, d);
        wr(`OFF_FLAGS, 32'h000);
        for (int k = 0; k < 12; k++) begin
            r = (k == 0) ? 16'h0000 : (k == 1) ? 16'h8000 : 16'($urandom());
            alu(r, k[0], k[1]);
            check({21'h0, processor_state_flags},
                  {21'h0, alu_flags(r, k[0], k[1])});
        end
        // Every request level against level three, then one with interrupts masked.
        for (int k = 0; k < 9; k++) begin
            f = (k == 8) ? 11'h380 : 11'h3C0;
            p = (k == 8) ? 3'h7 : 3'(k);
            wr(`OFF_FLAGS, {21'h0, f});
            irq(p, a1, a2);
            check({31'h0, a1}, {31'h0, take(f, p)});
            check({31'h0, a2}, 32'h0);
            check({21'h0, processor_state_flags},
                  {21'h0, take(f, p) ? f & 11'h73F : f});
        end
        for (int k = 0; k < 5; k++) begin
            n = (k == 4) ? 6'($urandom()) : sw_tab[k];
            wr(`OFF_FLAGS, 32'h080);
            pulse_core(1'b1, n, 20'h00000);
            check({21'h0, processor_state_flags},
                  {21'h0, n <= 6'h1F ? 11'h000 : 11'h080});
        end
        v = 20'($urandom());
        pulse_core(1'b0, 6'h00, v);
        rd(`OFF_NIP, q);
        check(q, {12'h0, v});
        apb(1'b0, 12'h054, 32'h0, q, e);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
        stop_test();
    end

endmodule : cpu_register_set_and_flags_tb
